// >>> spz_pkg.sv
// Constants, states and carriers shared by serial port zero
package spz_pkg;

  // Register addresses in the special-function-register space
  localparam logic [7:0] SPZ_ADDR_CONTROL = 8'h98;
  localparam logic [7:0] SPZ_ADDR_DATA = 8'h99;
  localparam logic [7:0] SPZ_ADDR_NODE = 8'hA9;
  localparam logic [7:0] SPZ_ADDR_MASK = 8'hB9;

  // Reset values
  localparam logic [7:0] SPZ_RESET_BYTE = 8'h00;

  // Field positions in serial_control
  localparam int SPZ_BIT_MODE_HIGH = 7;
  localparam int SPZ_BIT_MODE_LOW = 6;
  localparam int SPZ_BIT_FILTER = 5;
  localparam int SPZ_BIT_RX_ALLOW = 4;
  localparam int SPZ_BIT_TX_NINTH = 3;
  localparam int SPZ_BIT_RX_NINTH = 2;
  localparam int SPZ_BIT_TX_DONE = 1;
  localparam int SPZ_BIT_RX_DONE = 0;

  // Mode codes
  localparam logic [1:0] SPZ_MODE_SYNC = 2'h0;
  localparam logic [1:0] SPZ_MODE_ASYNC10 = 2'h1;
  localparam logic [1:0] SPZ_MODE_FIXED11 = 2'h2;
  localparam logic [1:0] SPZ_MODE_VAR11 = 2'h3;

  // Timing: mode 0 shift clock divisors, mode 2 oversample divisors (64/16, 32/16)
  localparam logic [3:0] SPZ_SYNC_DIV_SLOW = 4'hC;
  localparam logic [3:0] SPZ_SYNC_DIV_FAST = 4'h4;
  localparam logic [1:0] SPZ_FIXED_SUB_SLOW = 2'h3;
  localparam logic [1:0] SPZ_FIXED_SUB_FAST = 2'h1;
  localparam logic [3:0] SPZ_TICK_LAST = 4'hF;
  localparam logic [3:0] SPZ_TICK_MID = 4'h7;
  localparam logic [3:0] SPZ_BITS_SHORT = 4'h8;
  localparam logic [3:0] SPZ_BITS_LONG = 4'h9;
  localparam int SPZ_FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    SPZ_ST_IDLE = 4'b0001,
    SPZ_ST_START = 4'b0010,
    SPZ_ST_DATA = 4'b0100,
    SPZ_ST_STOP = 4'b1000
  } spz_state_e;

  // Transmit word: data with its ninth bit captured at the buffer write
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } spz_tx_word_s;

endpackage : spz_pkg

// >>> spz_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module spz_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      if (push && !pop)
        count <= count + (AW+1)'(1);
      else if (pop && !push)
        count <= count - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule : spz_fifo

// >>> spz_serial_port.sv
// Serial port zero: control, buffers, address filter and shift engines
`timescale 1ns/100ps
module spz_serial_port #(
  parameter int FIFO_DEPTH = spz_pkg::SPZ_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic frame_error_select,
  input wire logic serial_irq_allow,
  input wire logic global_irq_allow,
  input wire logic fixed_rate_double,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic rx_baud_source,
  input wire logic tx_baud_source,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd,
  output logic tx_buffer_ready,
  output logic serial_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Hardware set wins over a software write in the same cycle
  function automatic logic flag_next(input logic cur, input logic set, input logic wr, input logic wval);
    flag_next = set | (wr ? wval : cur);
  endfunction : flag_next

  function automatic logic addr_hit(input logic [7:0] data, input logic [7:0] node, input logic [7:0] mask);
    addr_hit = (((data ^ node) & mask) == 8'h00);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic mode_select_high;
  logic mode_select_low;
  logic multiproc_filter_bit;
  logic rx_allow;
  logic tx_ninth_bit;
  logic rx_ninth_bit;
  logic tx_done_flag;
  logic rx_done_flag;
  logic framing_fault_flag;
  logic [7:0] rx_buffer;
  logic [7:0] own_node_address;
  logic [7:0] node_address_mask;

  wire wr_ctl = sfr_wr && (sfr_addr == spz_pkg::SPZ_ADDR_CONTROL);
  wire wr_data = sfr_wr && (sfr_addr == spz_pkg::SPZ_ADDR_DATA);
  wire wr_node = sfr_wr && (sfr_addr == spz_pkg::SPZ_ADDR_NODE);
  wire wr_mask = sfr_wr && (sfr_addr == spz_pkg::SPZ_ADDR_MASK);
  wire [1:0] mode = {mode_select_high, mode_select_low};
  wire mode_sync = (mode == spz_pkg::SPZ_MODE_SYNC);
  wire mode_async10 = (mode == spz_pkg::SPZ_MODE_ASYNC10);
  wire mode_fixed = (mode == spz_pkg::SPZ_MODE_FIXED11);
  wire [3:0] frame_bits = mode_async10 ? spz_pkg::SPZ_BITS_SHORT : spz_pkg::SPZ_BITS_LONG;

  // Bit 7 shows the fault flag or the mode bit
  wire bit7_view = frame_error_select ? framing_fault_flag : mode_select_high;
  wire [7:0] control_view = {bit7_view, mode_select_low, multiproc_filter_bit, rx_allow,
                             tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
  wire [7:0] next_rdata = (sfr_addr == spz_pkg::SPZ_ADDR_CONTROL) ? control_view :
                          (sfr_addr == spz_pkg::SPZ_ADDR_DATA) ? rx_buffer :
                          (sfr_addr == spz_pkg::SPZ_ADDR_NODE) ? own_node_address :
                          (sfr_addr == spz_pkg::SPZ_ADDR_MASK) ? node_address_mask :
                          spz_pkg::SPZ_RESET_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO

  spz_pkg::spz_tx_word_s fifo_in;
  spz_pkg::spz_tx_word_s fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic tx_pop;

  assign fifo_in = '{ninth: tx_ninth_bit, data: sfr_wdata};

  spz_fifo #(
    .WIDTH($bits(spz_pkg::spz_tx_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(wr_data),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(tx_pop),
    .out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Rate generation

  spz_pkg::spz_state_e tx_state;
  spz_pkg::spz_state_e rx_state;
  logic [3:0] sync_cnt;
  logic [1:0] fixed_cnt;

  wire [3:0] sync_div = multiproc_filter_bit ? spz_pkg::SPZ_SYNC_DIV_FAST : spz_pkg::SPZ_SYNC_DIV_SLOW;
  wire [3:0] sync_last = sync_div - 4'h1;
  wire tx_sync_busy = mode_sync && (tx_state == spz_pkg::SPZ_ST_DATA);
  wire rx_sync_busy = mode_sync && (rx_state == spz_pkg::SPZ_ST_DATA);
  wire sync_active = tx_sync_busy || rx_sync_busy;
  wire sync_tick = sync_active && (sync_cnt == sync_last);
  wire sync_phase = (sync_cnt >= {1'b0, sync_div[3:1]});
  wire [3:0] next_sync_cnt = (!sync_active || sync_tick) ? 4'h0 : sync_cnt + 4'h1;

  wire [1:0] fixed_last = fixed_rate_double ? spz_pkg::SPZ_FIXED_SUB_FAST : spz_pkg::SPZ_FIXED_SUB_SLOW;
  wire fixed_tick = (fixed_cnt == fixed_last);
  wire [1:0] next_fixed_cnt = fixed_tick ? 2'h0 : fixed_cnt + 2'h1;

  wire tx_timer_tick = tx_baud_source ? timer2_overflow : timer1_overflow;
  wire rx_timer_tick = rx_baud_source ? timer2_overflow : timer1_overflow;
  wire tx_tick = mode_fixed ? fixed_tick : tx_timer_tick;
  wire rx_tick = mode_fixed ? fixed_tick : rx_timer_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit engine

  spz_pkg::spz_state_e next_tx_state;
  logic [8:0] tx_shift;
  logic [8:0] next_tx_shift;
  logic [3:0] tx_bit;
  logic [3:0] next_tx_bit;
  logic [3:0] tx_sub;
  logic [3:0] next_tx_sub;
  logic tx_done_set;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_bit = tx_bit;
    next_tx_sub = tx_sub;
    tx_done_set = 1'b0;
    tx_pop = 1'b0;
    case (tx_state)
      spz_pkg::SPZ_ST_IDLE:
        // Async frames start on a baud tick so the start bit lasts a full bit
        if (fifo_out_valid && !rx_sync_busy && (mode_sync || tx_tick))
        begin
          tx_pop = 1'b1;
          next_tx_shift = fifo_out;
          next_tx_bit = 4'h0;
          next_tx_sub = 4'h0;
          next_tx_state = mode_sync ? spz_pkg::SPZ_ST_DATA : spz_pkg::SPZ_ST_START;
        end
      spz_pkg::SPZ_ST_START:
        if (tx_tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub == spz_pkg::SPZ_TICK_LAST)
            next_tx_state = spz_pkg::SPZ_ST_DATA;
        end
      spz_pkg::SPZ_ST_DATA:
        if (mode_sync)
        begin
          if (sync_tick)
          begin
            next_tx_shift = {1'b1, tx_shift[8:1]};
            next_tx_bit = tx_bit + 4'h1;
            if (tx_bit == spz_pkg::SPZ_BITS_SHORT - 4'h1)
            begin
              tx_done_set = 1'b1;
              next_tx_state = spz_pkg::SPZ_ST_IDLE;
            end
          end
        end
        else if (tx_tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub == spz_pkg::SPZ_TICK_LAST)
          begin
            next_tx_shift = {1'b1, tx_shift[8:1]};
            next_tx_bit = tx_bit + 4'h1;
            if (tx_bit == frame_bits - 4'h1)
            begin
              tx_done_set = 1'b1;
              next_tx_state = spz_pkg::SPZ_ST_STOP;
            end
          end
        end
      spz_pkg::SPZ_ST_STOP:
        if (tx_tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub == spz_pkg::SPZ_TICK_LAST)
            next_tx_state = spz_pkg::SPZ_ST_IDLE;
        end
      default:
        next_tx_state = spz_pkg::SPZ_ST_IDLE;
    endcase
  end

  wire next_txd = sync_active ? sync_phase :
                  (tx_state == spz_pkg::SPZ_ST_START) ? 1'b0 :
                  (tx_state == spz_pkg::SPZ_ST_DATA) ? tx_shift[0] : 1'b1;
  wire next_rxd_oe_n = !tx_sync_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Receive engine

  spz_pkg::spz_state_e next_rx_state;
  logic [8:0] rx_shift;
  logic [8:0] next_rx_shift;
  logic [3:0] rx_bit;
  logic [3:0] next_rx_bit;
  logic [3:0] rx_sub;
  logic [3:0] next_rx_sub;
  logic rx_load;
  logic fault_set;

  wire [7:0] rx_word = mode_async10 || mode_sync ? rx_shift[8:1] : rx_shift[7:0];
  wire rx_ninth = rx_shift[8];
  wire node_match = addr_hit(rx_word, own_node_address, node_address_mask);
  wire accept_async = !rx_done_flag &&
                      (mode_async10 ? (!multiproc_filter_bit || rxd_in) :
                      (!multiproc_filter_bit || (rx_ninth && node_match)));

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_bit = rx_bit;
    next_rx_sub = rx_sub;
    rx_load = 1'b0;
    fault_set = 1'b0;
    case (rx_state)
      spz_pkg::SPZ_ST_IDLE:
        if (mode_sync)
        begin
          if (rx_allow && !rx_done_flag && tx_state == spz_pkg::SPZ_ST_IDLE && !fifo_out_valid)
          begin
            next_rx_bit = 4'h0;
            next_rx_state = spz_pkg::SPZ_ST_DATA;
          end
        end
        else if (rx_allow && rx_tick && !rxd_in)
        begin
          next_rx_sub = 4'h1;
          next_rx_state = spz_pkg::SPZ_ST_START;
        end
      spz_pkg::SPZ_ST_START:
        if (rx_tick)
        begin
          next_rx_sub = rx_sub + 4'h1;
          if (rx_sub == spz_pkg::SPZ_TICK_MID && rxd_in)
            next_rx_state = spz_pkg::SPZ_ST_IDLE;
          else if (rx_sub == spz_pkg::SPZ_TICK_LAST)
          begin
            next_rx_bit = 4'h0;
            next_rx_state = spz_pkg::SPZ_ST_DATA;
          end
        end
      spz_pkg::SPZ_ST_DATA:
        if (mode_sync)
        begin
          if (sync_tick)
          begin
            next_rx_shift = {rxd_in, rx_shift[8:1]};
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == spz_pkg::SPZ_BITS_SHORT - 4'h1)
              next_rx_state = spz_pkg::SPZ_ST_STOP;
          end
        end
        else if (rx_tick)
        begin
          next_rx_sub = rx_sub + 4'h1;
          if (rx_sub == spz_pkg::SPZ_TICK_MID)
            next_rx_shift = {rxd_in, rx_shift[8:1]};
          if (rx_sub == spz_pkg::SPZ_TICK_LAST)
          begin
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == frame_bits - 4'h1)
              next_rx_state = spz_pkg::SPZ_ST_STOP;
          end
        end
      spz_pkg::SPZ_ST_STOP:
        if (mode_sync)
        begin
          rx_load = 1'b1;
          next_rx_state = spz_pkg::SPZ_ST_IDLE;
        end
        else if (rx_tick)
        begin
          next_rx_sub = rx_sub + 4'h1;
          if (rx_sub == spz_pkg::SPZ_TICK_MID)
          begin
            fault_set = !rxd_in;
            rx_load = accept_async;
            next_rx_state = spz_pkg::SPZ_ST_IDLE;
          end
        end
      default:
        next_rx_state = spz_pkg::SPZ_ST_IDLE;
    endcase
    if (!rx_allow)
      next_rx_state = spz_pkg::SPZ_ST_IDLE;
  end

  // Mode 1 keeps the stop bit, modes 2/3 the ninth bit, mode 0 leaves it
  wire next_rx_ninth_bit = !rx_load ? rx_ninth_bit :
                           mode_sync ? rx_ninth_bit :
                           mode_async10 ? rxd_in : rx_ninth;

  wire next_irq = (tx_done_flag || rx_done_flag) && serial_irq_allow && global_irq_allow;

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_state <= spz_pkg::SPZ_ST_IDLE;
      rx_state <= spz_pkg::SPZ_ST_IDLE;
      tx_shift <= '1;
      rx_shift <= '0;
      tx_bit <= 4'h0;
      rx_bit <= 4'h0;
      tx_sub <= 4'h0;
      rx_sub <= 4'h0;
      sync_cnt <= 4'h0;
      fixed_cnt <= 2'h0;
    end
    else
    begin
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      tx_bit <= next_tx_bit;
      rx_bit <= next_rx_bit;
      tx_sub <= next_tx_sub;
      rx_sub <= next_rx_sub;
      sync_cnt <= next_sync_cnt;
      fixed_cnt <= next_fixed_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_select_high <= 1'b0;
      mode_select_low <= 1'b0;
      multiproc_filter_bit <= 1'b0;
      rx_allow <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_fault_flag <= 1'b0;
      rx_buffer <= spz_pkg::SPZ_RESET_BYTE;
      own_node_address <= spz_pkg::SPZ_RESET_BYTE;
      node_address_mask <= spz_pkg::SPZ_RESET_BYTE;
    end
    else
    begin
      if (wr_ctl && !frame_error_select)
        mode_select_high <= sfr_wdata[spz_pkg::SPZ_BIT_MODE_HIGH];
      if (wr_ctl)
      begin
        mode_select_low <= sfr_wdata[spz_pkg::SPZ_BIT_MODE_LOW];
        multiproc_filter_bit <= sfr_wdata[spz_pkg::SPZ_BIT_FILTER];
        rx_allow <= sfr_wdata[spz_pkg::SPZ_BIT_RX_ALLOW];
        tx_ninth_bit <= sfr_wdata[spz_pkg::SPZ_BIT_TX_NINTH];
      end
      rx_ninth_bit <= rx_load ? next_rx_ninth_bit :
                      (wr_ctl ? sfr_wdata[spz_pkg::SPZ_BIT_RX_NINTH] : rx_ninth_bit);
      tx_done_flag <= flag_next(tx_done_flag, tx_done_set, wr_ctl, sfr_wdata[spz_pkg::SPZ_BIT_TX_DONE]);
      rx_done_flag <= flag_next(rx_done_flag, rx_load, wr_ctl, sfr_wdata[spz_pkg::SPZ_BIT_RX_DONE]);
      framing_fault_flag <= flag_next(framing_fault_flag, fault_set, wr_ctl && frame_error_select,
                                      sfr_wdata[spz_pkg::SPZ_BIT_MODE_HIGH]);
      if (rx_load)
        rx_buffer <= rx_word;
      if (wr_node)
        own_node_address <= sfr_wdata;
      if (wr_mask)
        node_address_mask <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_rdata <= spz_pkg::SPZ_RESET_BYTE;
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
      tx_buffer_ready <= 1'b0;
      serial_irq <= 1'b0;
    end
    else
    begin
      if (sfr_rd)
        sfr_rdata <= next_rdata;
      txd <= next_txd;
      rxd_out <= tx_shift[0];
      rxd_oe_n <= next_rxd_oe_n;
      tx_buffer_ready <= fifo_in_ready;
      serial_irq <= next_irq;
    end
  end

endmodule : spz_serial_port

// >>> spz_serial_port_chk.sv
// Port-level assertions for serial port zero
`timescale 1ns/100ps
module spz_serial_port_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic frame_error_select,
  input wire logic serial_irq_allow,
  input wire logic global_irq_allow,
  input wire logic fixed_rate_double,
  input wire logic txd,
  input wire logic serial_irq
);
  logic [1:0] mode;
  logic fast;
  logic [9:0] low_run;
  wire ctl_wr = sfr_wr && sfr_addr == spz_pkg::SPZ_ADDR_CONTROL;
  wire irq_on = serial_irq_allow && global_irq_allow;
  wire unmapped = sfr_addr != spz_pkg::SPZ_ADDR_CONTROL && sfr_addr != spz_pkg::SPZ_ADDR_DATA &&
    sfr_addr != spz_pkg::SPZ_ADDR_NODE && sfr_addr != spz_pkg::SPZ_ADDR_MASK;

  ////////////////////////////////////////////////////////////////
  // Shadow of software mode bits and length of low runs on txd
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode <= 2'h0;
      fast <= 1'b0;
      low_run <= 10'h000;
    end
    else
    begin
      low_run <= txd ? 10'h000 : low_run + 10'h001;
      if (ctl_wr)
      begin
        mode[0] <= sfr_wdata[6];
        fast <= sfr_wdata[5];
        if (!frame_error_select)
          mode[1] <= sfr_wdata[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_IRQ_GATE: assert property (serial_irq |-> $past(irq_on))
    else $error("interrupt raised without both enables");
  AST_IRQ_CLEAR: assert property ($fell(serial_irq) && $past(irq_on) && $past(irq_on, 2) |-> $past(ctl_wr, 2))
    else $error("interrupt dropped without a control write");
  AST_RDATA_HOLD: assert property (!$past(sfr_rd) && !$past(sfr_rd, 2) |-> $stable(sfr_rdata))
    else $error("read data changed without a read");
  AST_UNMAPPED_ZERO: assert property (sfr_rd && unmapped |-> ##2 sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_NODE_READBACK: assert property (sfr_wr && sfr_addr == spz_pkg::SPZ_ADDR_NODE ##2
    sfr_rd && sfr_addr == spz_pkg::SPZ_ADDR_NODE |-> ##2 sfr_rdata == $past(sfr_wdata, 4))
    else $error("node address readback wrong");
  AST_SYNC_FAST: assert property (mode == 2'h0 && fast && $fell(txd) |-> !txd[*2] ##1 txd[*2])
    else $error("fast shift clock not four cycles");
  AST_SYNC_SLOW: assert property (mode == 2'h0 && !fast && $fell(txd) |-> !txd[*6] ##1 txd[*6])
    else $error("slow shift clock not twelve cycles");
  AST_FIXED_BIT: assert property (mode == 2'h2 && fixed_rate_double && $rose(txd) |-> low_run[4:0] == 5'h00)
    else $error("fixed rate bit not 32 cycles");

  cover property (mode == 2'h0 && $fell(txd));
  cover property ($rose(serial_irq));
  cover property (mode == 2'h2 && $rose(txd));
endmodule : spz_serial_port_chk

bind spz_serial_port spz_serial_port_chk u_chk (.mclk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .frame_error_select, .serial_irq_allow, .global_irq_allow, .fixed_rate_double, .txd, .serial_irq);

// >>> spz_peer.sv
// Remote serial peer: frame sender and txd decoder
`timescale 1ns/100ps
module spz_peer (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd_in
);
  int bit_clks = 64;
  int nbits = 8;
  logic listen = 1'b0;
  logic [8:0] rx_word = 9'h000;
  event got;

  // Pulled-up line: high when idle
  initial rxd_in = 1'b1;

  task automatic send(input logic [8:0] w, input logic stop);
    @(negedge mclk);
    for (int i = 0; i < nbits + 2; i++)
    begin
      rxd_in = (i == 0) ? 1'b0 : (i <= nbits) ? w[i-1] : stop;
      repeat (bit_clks) @(negedge mclk);
    end
    rxd_in = 1'b1;
  endtask : send

  ////////////////////////////////////////////////////////////////
  always
  begin
    @(negedge txd);
    if (listen)
    begin
      rx_word = 9'h000;
      repeat (bit_clks / 2) @(posedge mclk);
      for (int i = 0; i < nbits; i++)
      begin
        repeat (bit_clks) @(posedge mclk);
        rx_word[i] = txd;
      end
      -> got;
      repeat (bit_clks) @(posedge mclk);
    end
  end
endmodule : spz_peer

// >>> spz_serial_port_tb.sv
// Self-checking bench for serial port zero
`timescale 1ns/100ps
module spz_serial_port_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic frame_error_select = 1'b0;
  logic serial_irq_allow = 1'b1;
  logic global_irq_allow = 1'b1;
  logic fixed_rate_double = 1'b1;
  logic timer1_overflow = 1'b0;
  logic timer2_overflow = 1'b0;
  logic rx_baud_source = 1'b0;
  logic tx_baud_source = 1'b1;
  logic rxd_in;
  logic [7:0] sfr_rdata;
  logic rxd_out;
  logic rxd_oe_n;
  logic txd;
  logic tx_buffer_ready;
  logic serial_irq;
  logic [8:0] q_rd[$];
  logic [8:0] q_fr[$];
  logic [7:0] d;
  logic [7:0] m0_word = 8'h00;
  int seed = 84;
  int tick = 0;
  int miscompares = 0;
  int n_checks = 0;
  localparam logic [7:0] C = spz_pkg::SPZ_ADDR_CONTROL;
  localparam logic [7:0] D = spz_pkg::SPZ_ADDR_DATA;

  spz_serial_port dut (.mclk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .frame_error_select, .serial_irq_allow, .global_irq_allow, .fixed_rate_double, .timer1_overflow,
    .timer2_overflow, .rx_baud_source, .tx_baud_source, .rxd_in, .rxd_out, .rxd_oe_n, .txd,
    .tx_buffer_ready, .serial_irq);
  spz_peer peer (.mclk, .txd, .rxd_in);

  always #25 mclk = ~mclk;

  // Mode 0 capture: data on rxd_out at each rising shift clock
  always @(posedge txd)
    if (!rxd_oe_n)
      m0_word = {rxd_out, m0_word[7:1]};

  // Baud ticks: timer 1 every 4 clocks, timer 2 every 2
  always @(negedge mclk)
  begin
    tick++;
    timer1_overflow = (tick % 4) == 0;
    timer2_overflow = (tick % 2) == 0;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    q_rd.push_back({1'b0, e});
    @(negedge mclk);
    sfr_rd = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : rd

  task automatic send_tx(input logic [8:0] w);
    q_fr.push_back(w);
    wr(D, w[7:0]);
    for (int k = 0; k < 4000 && q_fr.size() != 0; k++)
      @(negedge mclk);
    check("frames left", 9'(q_fr.size()), 9'h000);
    repeat (2 * peer.bit_clks) @(negedge mclk);
  endtask : send_tx

  ////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    if (sfr_rd)
    begin
      repeat (2) @(negedge mclk);
      check("read", {1'b0, sfr_rdata}, q_rd.pop_front());
    end
  end

  always @(peer.got) check("frame", peer.rx_word, q_fr.pop_front());

  initial
  begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    results;
  end

  initial
  begin
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    rd(C, 8'h00);
    rd(8'hAA, 8'h00);
    d = 8'($random(seed));
    wr(spz_pkg::SPZ_ADDR_NODE, d);
    rd(spz_pkg::SPZ_ADDR_NODE, d);
    wr(spz_pkg::SPZ_ADDR_MASK, 8'h00);
    // Mode 1 transmit paced by timer 2
    peer.bit_clks = 32;
    peer.listen = 1'b1;
    wr(C, 8'h50);
    send_tx({1'b0, 8'($random(seed))});
    rd(C, 8'h52);
    check("irq", {8'h00, serial_irq}, 9'h001);
    serial_irq_allow = 1'b0;
    repeat (2) @(negedge mclk);
    check("irq gated", {8'h00, serial_irq}, 9'h000);
    serial_irq_allow = 1'b1;
    // Mode 3 receive paced by timer 1
    peer.bit_clks = 64;
    peer.nbits = 9;
    wr(C, 8'hD0);
    d = 8'($random(seed));
    peer.send({1'b1, d}, 1'b1);
    rd(D, d);
    rd(C, 8'hD5);
    wr(C, 8'hF0);
    peer.send({1'b0, 8'($random(seed))}, 1'b1);
    rd(C, 8'hF0);
    rd(D, d);
    d = 8'($random(seed));
    peer.send({1'b1, d}, 1'b1);
    rd(C, 8'hF5);
    rd(D, d);
    wr(spz_pkg::SPZ_ADDR_NODE, d);
    wr(spz_pkg::SPZ_ADDR_MASK, 8'hF0);
    wr(C, 8'hF0);
    peer.send({1'b1, d ^ 8'h10}, 1'b1);
    rd(C, 8'hF0);
    peer.send({1'b1, d ^ 8'h01}, 1'b1);
    rd(D, d ^ 8'h01);
    // Receive refused, then a bad stop bit
    peer.nbits = 8;
    wr(C, 8'h70);
    peer.send({1'b0, 8'($random(seed))}, 1'b0);
    rd(C, 8'h70);
    wr(C, 8'h40);
    peer.send({1'b0, 8'($random(seed))}, 1'b1);
    rd(C, 8'h40);
    frame_error_select = 1'b1;
    wr(C, 8'h54);
    peer.send({1'b0, 8'($random(seed))}, 1'b0);
    rd(C, 8'hD1);
    frame_error_select = 1'b0;
    rd(C, 8'h51);
    // Mode 2 transmit with ninth bit set
    peer.bit_clks = 32;
    peer.nbits = 9;
    wr(C, 8'h88);
    send_tx({1'b1, 8'($random(seed))});
    rd(C, 8'h8A);
    // Mode 0 transmit, fast shift clock
    peer.listen = 1'b0;
    wr(C, 8'h20);
    d = 8'($random(seed));
    wr(D, d);
    repeat (8 * 4 + 8) @(negedge mclk);
    check("shift out", {1'b0, m0_word}, {1'b0, d});
    rd(C, 8'h22);
    // Mode 0 receive of an idle line, then transmit with slow shift clock
    wr(C, 8'h30);
    repeat (8 * 4 + 8) @(negedge mclk);
    rd(D, 8'hFF);
    rd(C, 8'h31);
    wr(C, 8'h00);
    d = 8'($random(seed));
    wr(D, d);
    repeat (8) @(negedge mclk);
    check("drive", {8'h00, rxd_oe_n}, 9'h000);
    check("ready", {8'h00, tx_buffer_ready}, 9'h001);
    repeat (8 * 12) @(negedge mclk);
    check("release", {8'h00, rxd_oe_n}, 9'h001);
    check("shift out", {1'b0, m0_word}, {1'b0, d});
    rd(C, 8'h02);
    results;
  end
endmodule : spz_serial_port_tb
